// *** core/adc_result_pkg.sv ***
// constants for the conversion result justifier
package adc_result_pkg;
  localparam int RESULT_WIDTH = 10;
  localparam int BYTE_WIDTH = 8;
  localparam int ADDR_WIDTH = 12;
  localparam int DATA_WIDTH = 32;

  // byte addresses, one aligned word each
  localparam logic [11:0] ADDR_RESULT_HIGH = 12'h000;
  localparam logic [11:0] ADDR_RESULT_LOW = 12'h004;
  localparam logic [11:0] ADDR_CONTROL = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00C;

  // decoded register select
  localparam logic [2:0] SEL_NONE = 3'h0;
  localparam logic [2:0] SEL_HIGH = 3'h1;
  localparam logic [2:0] SEL_LOW = 3'h2;
  localparam logic [2:0] SEL_CONTROL = 3'h3;
  localparam logic [2:0] SEL_STATUS = 3'h4;

  // field positions
  localparam int CTRL_JUSTIFY_BIT = 0;
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_OVERRUN_BIT = 1;

  // reset values
  localparam logic CTRL_JUSTIFY_RESET = 1'b0;
  localparam logic [31:0] PRDATA_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    APB_IDLE = 2'b00,
    APB_ANSWER = 2'b01
  } apb_state_type;
endpackage : adc_result_pkg

// *** core/justify_if.sv ***
// carrier between the register file and the justifier
`timescale 1ns/1ps
interface justify_if;
  logic [9:0] result;
  logic select;
  logic [7:0] high;
  logic [7:0] low;
  modport producer (output result, output select, input high, input low);
  modport justifier (input result, input select, output high, output low);
endinterface : justify_if

// *** core/result_justifier.sv ***
// places a 10-bit result into a high and a low byte
`timescale 1ns/1ps
module result_justifier (
  justify_if.justifier jif
);
  // reserved positions are driven to zero so reads are repeatable
  always_comb begin
    if (jif.select) begin
      jif.high = {6'h00, jif.result[9:8]};
      jif.low = jif.result[7:0];
    end else begin
      jif.high = jif.result[9:2];
      jif.low = {jif.result[1:0], 6'h00};
    end
  end
endmodule : result_justifier

// *** core/adc_result_justifier.sv ***
// apb register file holding the justified conversion result
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
module adc_result_justifier (
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [9:0] CONV_RESULT_I,
  input wire logic CONV_DONE_I
);
  adc_result_pkg::apb_state_type state;
  adc_result_pkg::apb_state_type next_state;
  logic next_pready;
  logic next_slverr;
  logic [31:0] next_prdata;
  logic justify_select;
  logic next_justify_select;
  logic ready;
  logic next_ready;
  logic overrun;
  logic next_overrun;
  logic [7:0] result_high;
  logic [7:0] next_result_high;
  logic [7:0] result_low;
  logic [7:0] next_result_low;
  logic [2:0] sel;
  logic access;
  logic complete;
  logic read_low_now;
  logic have_result;
  logic next_have_result;

  justify_if jif ();

  assign jif.result = CONV_RESULT_I;
  assign jif.select = justify_select;

  result_justifier result_justifier_inst (
    .jif(jif)
  );

  function automatic logic [2:0] reg_decode(input logic [11:0] addr);
    if (addr == adc_result_pkg::ADDR_RESULT_HIGH) begin
      reg_decode = adc_result_pkg::SEL_HIGH;
    end else if (addr == adc_result_pkg::ADDR_RESULT_LOW) begin
      reg_decode = adc_result_pkg::SEL_LOW;
    end else if (addr == adc_result_pkg::ADDR_CONTROL) begin
      reg_decode = adc_result_pkg::SEL_CONTROL;
    end else if (addr == adc_result_pkg::ADDR_STATUS) begin
      reg_decode = adc_result_pkg::SEL_STATUS;
    end else begin
      reg_decode = adc_result_pkg::SEL_NONE;
    end
  endfunction : reg_decode

  assign sel = reg_decode(PADDR_I);
  assign access = (state == adc_result_pkg::APB_IDLE) && PSEL_I && PENABLE_I;
  // master holds the request until it sees pready, so answer cycle closes it
  assign complete = (state == adc_result_pkg::APB_ANSWER);
  assign read_low_now = complete && !PWRITE_I && (sel == adc_result_pkg::SEL_LOW);

  always_comb begin
    next_state = state;
    next_pready = 1'b0;
    next_slverr = 1'b0;
    next_prdata = adc_result_pkg::PRDATA_RESET;
    next_justify_select = justify_select;
    next_ready = ready;
    next_overrun = overrun;
    next_result_high = result_high;
    next_result_low = result_low;
    if (access) begin
      next_state = adc_result_pkg::APB_ANSWER;
      next_pready = 1'b1;
      if (sel == adc_result_pkg::SEL_NONE) begin
        next_slverr = 1'b1;
      end else if (PWRITE_I && (sel == adc_result_pkg::SEL_HIGH ||
                                sel == adc_result_pkg::SEL_LOW)) begin
        next_slverr = 1'b1;
      end else if (!PWRITE_I && sel == adc_result_pkg::SEL_HIGH) begin
        next_prdata = {24'h000000, result_high};
      end else if (!PWRITE_I && sel == adc_result_pkg::SEL_LOW) begin
        next_prdata = {24'h000000, result_low};
      end else if (!PWRITE_I && sel == adc_result_pkg::SEL_CONTROL) begin
        next_prdata[adc_result_pkg::CTRL_JUSTIFY_BIT] = justify_select;
      end else if (!PWRITE_I) begin
        next_prdata[adc_result_pkg::STAT_READY_BIT] = ready;
        next_prdata[adc_result_pkg::STAT_OVERRUN_BIT] = overrun;
      end
    end
    if (complete) begin
      next_state = adc_result_pkg::APB_IDLE;
      if (PWRITE_I && sel == adc_result_pkg::SEL_CONTROL) begin
        next_justify_select = PWDATA_I[adc_result_pkg::CTRL_JUSTIFY_BIT];
      end
      if (PWRITE_I && sel == adc_result_pkg::SEL_STATUS &&
          PWDATA_I[adc_result_pkg::STAT_OVERRUN_BIT]) begin
        next_overrun = 1'b0;
      end
      if (read_low_now) begin
        next_ready = 1'b0;
      end
    end
    // a finished conversion wins over a clear in the same cycle
    if (CONV_DONE_I) begin
      next_result_high = jif.high;
      next_result_low = jif.low;
      next_ready = 1'b1;
      if (ready && !read_low_now) begin
        next_overrun = 1'b1;
      end
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      state <= adc_result_pkg::APB_IDLE;
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= adc_result_pkg::PRDATA_RESET;
      justify_select <= adc_result_pkg::CTRL_JUSTIFY_RESET;
      ready <= 1'b0;
      overrun <= 1'b0;
    end else begin
      state <= next_state;
      PREADY_O <= next_pready;
      PSLVERR_O <= next_slverr;
      PRDATA_O <= next_prdata;
      justify_select <= next_justify_select;
      ready <= next_ready;
      overrun <= next_overrun;
    end
  end

  // result bytes carry no reset: their content is undefined until a conversion
  always_ff @(posedge SYS_CLK_I) begin
    result_high <= next_result_high;
    result_low <= next_result_low;
  end

  // helper for the checks below only: bytes are unknown before the first load
  always_comb begin
    next_have_result = have_result || CONV_DONE_I;
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      have_result <= 1'b0;
    end else begin
      have_result <= next_have_result;
    end
  end

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);

  sequence left_done;
    CONV_DONE_I && !justify_select;
  endsequence
  sequence right_done;
    CONV_DONE_I && justify_select;
  endsequence
  sequence ro_write;
    access && PWRITE_I && (sel == adc_result_pkg::SEL_HIGH || sel == adc_result_pkg::SEL_LOW);
  endsequence
  sequence high_read;
    access && !PWRITE_I && (sel == adc_result_pkg::SEL_HIGH);
  endsequence
  sequence ctrl_write;
    complete && PWRITE_I && (sel == adc_result_pkg::SEL_CONTROL);
  endsequence
  sequence unmapped_access;
    access && (sel == adc_result_pkg::SEL_NONE);
  endsequence

  a_left_high_byte: assert property (
    left_done |=> result_high == $past(CONV_RESULT_I[9:2]))
    else $error("left mode high byte wrong");
  a_left_low_byte: assert property (
    left_done |=> result_low == {$past(CONV_RESULT_I[1:0]), 6'h00})
    else $error("left mode low byte wrong");
  a_right_high_byte: assert property (
    right_done |=> result_high == {6'h00, $past(CONV_RESULT_I[9:8])})
    else $error("right mode high byte wrong");
  a_right_low_byte: assert property (
    right_done |=> result_low == $past(CONV_RESULT_I[7:0]))
    else $error("right mode low byte wrong");
  a_result_read_only: assert property (
    // the refusal stands in the cycle after the take, then both bytes stay put
    ro_write ##1 !CONV_DONE_I |-> (PSLVERR_O && PREADY_O) ##1
      (!PREADY_O && $stable(result_low) && $stable(result_high)))
    else $error("write to result byte not refused");
  a_bytes_hold_together: assert property (
    have_result && !CONV_DONE_I |=> $stable(result_high) && $stable(result_low))
    else $error("result bytes changed without conversion");
  a_high_read_data: assert property (
    high_read |=> PREADY_O && !PSLVERR_O && PRDATA_O == {24'h000000, $past(result_high)})
    else $error("high byte read returned wrong data");
  a_ready_flag_set: assert property (
    CONV_DONE_I |=> ready [*1] ##1 (ready || $past(read_low_now)))
    else $error("result ready flag not set");
  a_control_takes_write: assert property (
    ctrl_write |=> justify_select == $past(PWDATA_I[adc_result_pkg::CTRL_JUSTIFY_BIT]))
    else $error("control write not taken");
  a_unmapped_refused: assert property (
    unmapped_access |=> PREADY_O && PSLVERR_O && PRDATA_O == adc_result_pkg::PRDATA_RESET)
    else $error("unmapped access not refused");
  a_ready_single_pulse: assert property (
    PREADY_O |=> !PREADY_O)
    else $error("pready stood longer than one cycle");
endmodule : adc_result_justifier

// *** verif/adc_result_justifier_tb.sv ***
// self-checking bench for the apb conversion result registers
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module adc_result_justifier_tb;
  logic SYS_CLK_I = 1'b0;
  logic RST_I = 1'b1;
  logic PSEL_I = 1'b0;
  logic PENABLE_I = 1'b0;
  logic PWRITE_I = 1'b0;
  logic [11:0] PADDR_I = 12'h000;
  logic [31:0] PWDATA_I = 32'h0000_0000;
  logic [31:0] PRDATA_O;
  logic PREADY_O;
  logic PSLVERR_O;
  logic [9:0] CONV_RESULT_I = 10'h000;
  logic CONV_DONE_I = 1'b0;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [31:0] q;
  logic e;
  logic [9:0] vals [4] = '{10'h3FF, 10'h000, 10'h2D7, 10'h155};

  adc_result_justifier adc_result_justifier_inst (
    .SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .CONV_RESULT_I(CONV_RESULT_I),
    .CONV_DONE_I(CONV_DONE_I)
  );

  always #2 SYS_CLK_I = ~SYS_CLK_I;

  task automatic complete_run();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  // a hung slave would stall a task forever
  always @(posedge SYS_CLK_I) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      complete_run();
    end
  end

  // entered just after a rising edge; returns one idle edge after the pready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    PSEL_I <= 1'b1;
    PWRITE_I <= w;
    PADDR_I <= a;
    PWDATA_I <= d;
    @(posedge SYS_CLK_I);
    PENABLE_I <= 1'b1;
    do @(posedge SYS_CLK_I); while (PREADY_O !== 1'b1);
    q = PRDATA_O;
    e = PSLVERR_O;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
    @(posedge SYS_CLK_I);
  endtask : apb

  task automatic conv(input logic [9:0] r);
    CONV_RESULT_I <= r;
    CONV_DONE_I <= 1'b1;
    @(posedge SYS_CLK_I);
    CONV_DONE_I <= 1'b0;
    CONV_RESULT_I <= ~r;
    @(posedge SYS_CLK_I);
  endtask : conv

  task automatic chk_result(input logic [9:0] r, input logic rj);
    logic [7:0] hi;
    apb(1'b0, adc_result_pkg::ADDR_RESULT_HIGH, 32'h0000_0000);
    hi = q[7:0];
    `CHK(q, rj ? {30'h0, r[9:8]} : {24'h0, r[9:2]})
    apb(1'b0, adc_result_pkg::ADDR_RESULT_LOW, 32'h0000_0000);
    `CHK(q, rj ? {24'h0, r[7:0]} : {24'h0, r[1:0], 6'h00})
    // software view: rebuild the result from the meaningful bits only
    `CHK(rj ? {hi[1:0], q[7:0]} : {hi, q[7:6]}, r)
  endtask : chk_result

  task automatic test_reset();
    apb(1'b0, adc_result_pkg::ADDR_CONTROL, 32'h0000_0000);
    `CHK({q, e}, 33'h0_0000_0000)
    apb(1'b0, adc_result_pkg::ADDR_STATUS, 32'h0000_0000);
    `CHK({q, e}, 33'h0_0000_0000)
  endtask : test_reset

  task automatic test_modes();
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, adc_result_pkg::ADDR_CONTROL, m);
      foreach (vals[i]) begin
        conv(vals[i]);
        chk_result(vals[i], m[0]);
      end
    end
  endtask : test_modes

  // result bytes refuse writes and keep their contents
  task automatic test_readonly();
    conv(10'h2D7);
    apb(1'b1, adc_result_pkg::ADDR_RESULT_HIGH, 32'hFFFF_FFFF);
    `CHK(e, 1'b1)
    apb(1'b1, adc_result_pkg::ADDR_RESULT_LOW, 32'hFFFF_FFFF);
    `CHK(e, 1'b1)
    chk_result(10'h2D7, 1'b1);
    apb(1'b0, 12'h010, 32'h0000_0000);
    `CHK({q, e}, 33'h0_0000_0001)
    apb(1'b0, 12'h002, 32'h0000_0000);
    `CHK(e, 1'b1)
  endtask : test_readonly

  // stored bytes keep the layout chosen when they were loaded
  task automatic test_hold();
    apb(1'b1, adc_result_pkg::ADDR_CONTROL, 32'h0000_0000);
    chk_result(10'h2D7, 1'b1);
    conv(10'h1A5);
    conv(10'h0C3);
    chk_result(10'h0C3, 1'b0);
  endtask : test_hold

  task automatic test_status();
    // overrun is left set by the back-to-back loads before; start clean
    apb(1'b1, adc_result_pkg::ADDR_STATUS, 32'h0000_0002);
    conv(10'h111);
    apb(1'b0, adc_result_pkg::ADDR_STATUS, 32'h0000_0000);
    `CHK(q[1:0], 2'h1)
    conv(10'h222);
    apb(1'b0, adc_result_pkg::ADDR_STATUS, 32'h0000_0000);
    `CHK(q[1:0], 2'h3)
    apb(1'b1, adc_result_pkg::ADDR_STATUS, 32'h0000_0002);
    apb(1'b0, adc_result_pkg::ADDR_RESULT_LOW, 32'h0000_0000);
    `CHK(q, {24'h0, 2'h2, 6'h00})
    apb(1'b0, adc_result_pkg::ADDR_STATUS, 32'h0000_0000);
    `CHK(q[1:0], 2'h0)
  endtask : test_status

  initial begin
    repeat (20) @(posedge SYS_CLK_I);
    RST_I <= 1'b0;
    @(posedge SYS_CLK_I);
    test_reset();
    test_modes();
    test_readonly();
    test_hold();
    test_status();
    complete_run();
  end
endmodule : adc_result_justifier_tb
